// ### design/qbsp_params.svh
// Constants of the burst SRAM port: timing, burst counts, lane layout.
// Assumes the core clock rate below; included by the package and the port.
`ifndef QBSP_PARAMS_SVH
`define QBSP_PARAMS_SVH
// Core clock rate in MHz and setup stage length in us
`define QBSP_CLK_MHZ 125
`define QBSP_SETUP_US 20
`define QBSP_SETUP_CYC (`QBSP_SETUP_US * `QBSP_CLK_MHZ)
// Core clock cycles without a link clock edge that count as stopped clock
`define QBSP_STALL_CYC 12'h040
// Byte lane width
`define QBSP_LANE_W 9
// Read slot count after the starting edge: valid on, first and last beat
`define QBSP_RD_VLD_ON 3'h3
`define QBSP_RD_BEAT0 3'h4
`define QBSP_RD_BEAT3 3'h7
`define QBSP_RD_VLD_LAST 3'h6
// Write slot count before the tick that captures the first and last beat
`define QBSP_WR_BEAT0 3'h1
`define QBSP_WR_BEAT3 3'h4
`endif

// ### design/qbsp_pkg.sv
// Types shared by the burst SRAM port.
// Assumes qbsp_params.svh is on the include path.
`include "qbsp_params.svh"
package qbsp_pkg;
    // Gray coded clock setup monitor
    typedef enum logic [1:0] {
        QBSP_SETUP_IDLE = 2'h0,
        QBSP_SETUP_RUN = 2'h1,
        QBSP_SETUP_DONE = 2'h3
    } qbsp_setup_e;
    // Half cycle count within a burst
    typedef logic [2:0] qbsp_tick_t;
endpackage : qbsp_pkg

// ### design/qbsp_port.sv
// Burst-of-four SRAM port with separate read and write data paths.
// Assumes all link pins are asynchronous to clk and the link clock is far slower.
//
// Local design decisions: the register addresses and the plain strobed port.
`include "qbsp_params.svh"

// Function
// - Valid rises half a cycle before the first read beat.
// - Valid falls half a cycle before the read burst ends.
// - Termination select low picks 0.3 x RQ; high or open picks 0.6 x RQ.
// - Read select high, write select low starts a write; beats on next two cycles.
// - Read select low starts a read; beats two and three cycles later.
// - Selects sampled on true edge; write data on both edges.
// - A repeated request on the next true edge is ignored.
// - Read outputs stay high impedance during power-up.
// - Wide part: four active-low strobes each enable one 9-bit lane.
// - Narrow part: two active-low strobes enable the two 9-bit lanes.
// - Strobes are sampled on every beat of a write.
// - Address extended by two bits stepping 0,1,2,3; four beats.
// - Read and write run together; read wins on the same edge.
// - Echo clocks run continuously, also while outputs float.
module qbsp_port #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link clock pair and commands
    input wire logic link_clk,
    input wire logic link_clk_n,
    input wire logic read_sel_n,
    input wire logic write_sel_n,
    input wire logic [ADDR_W-1:0] addr,
    // Write path
    input wire logic [DATA_W-1:0] write_data,
    input wire logic [DATA_W/`QBSP_LANE_W-1:0] byte_write_strobe_n,
    // Straps
    input wire logic pll_bypass_n,
    input wire logic termination_range_select,
    // Read path
    output logic [DATA_W-1:0] read_data,
    output logic read_data_oe,
    output logic read_data_valid,
    output logic echo_clock,
    output logic echo_clock_complement,
    // Status
    output logic term_range_high,
    output logic pll_in_use,
    output logic clock_setup_done
);
    import qbsp_pkg::*;

    localparam int LANES = DATA_W / `QBSP_LANE_W;
    localparam int SYN_W = 6 + ADDR_W + DATA_W + LANES;
    localparam int MEM_A = ADDR_W + 2;

    // Two-stage synchroniser for every pin
    logic [SYN_W-1:0] syn1_q;
    logic [SYN_W-1:0] syn2_q;
    logic [1:0] kprev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syn1_q <= '0;
            syn2_q <= '0;
        end else begin
            syn1_q <= {link_clk, link_clk_n, read_sel_n, write_sel_n, pll_bypass_n,
                       termination_range_select, addr, write_data, byte_write_strobe_n};
            syn2_q <= syn1_q;
        end
    end

    logic s_k;
    logic s_kn;
    logic s_rsel_n;
    logic s_wsel_n;
    logic s_pll;
    logic s_term;
    logic [ADDR_W-1:0] s_addr;
    logic [DATA_W-1:0] s_wdata;
    logic [LANES-1:0] s_bw_n;

    assign {s_k, s_kn, s_rsel_n, s_wsel_n, s_pll, s_term, s_addr, s_wdata, s_bw_n} = syn2_q;

    // Edge detection on the synchronised clock pair
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kprev_q <= '0;
        end else begin
            kprev_q <= {s_k, s_kn};
        end
    end

    logic k_rise;
    logic kn_rise;
    logic tick;

    assign k_rise = s_k & ~kprev_q[1];
    assign kn_rise = s_kn & ~kprev_q[0];
    assign tick = k_rise | kn_rise;

    // Command decode on the true edge only
    logic rd_req;
    logic wr_req;
    logic rd_start;
    logic wr_start;
    logic rd_prev_q;
    logic wr_prev_q;

    assign rd_req = k_rise & ~s_rsel_n;
    assign wr_req = k_rise & s_rsel_n & ~s_wsel_n;
    assign rd_start = rd_req & ~rd_prev_q;
    assign wr_start = wr_req & ~wr_prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else if (k_rise) begin
            rd_prev_q <= rd_start;
            wr_prev_q <= wr_start;
        end
    end

    // Two burst slots per direction: a start can land while the last beats run
    logic rd_slot_q;
    logic wr_slot_q;
    logic [1:0] rd_busy_q;
    logic [1:0] wr_busy_q;
    qbsp_tick_t rd_cnt_q [2];
    qbsp_tick_t wr_cnt_q [2];
    logic [ADDR_W-1:0] rd_addr_q [2];
    logic [ADDR_W-1:0] wr_addr_q [2];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_slot_q <= 1'b0;
            wr_slot_q <= 1'b0;
        end else begin
            rd_slot_q <= rd_slot_q ^ rd_start;
            wr_slot_q <= wr_slot_q ^ wr_start;
        end
    end

    logic [1:0] rd_drive;
    logic [1:0] rd_vld;
    logic [1:0] wr_beat;

    for (genvar s = 0; s < 2; s++) begin : g_slot
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                rd_busy_q[s] <= 1'b0;
                rd_cnt_q[s] <= '0;
                rd_addr_q[s] <= '0;
            end else if (rd_start && rd_slot_q == 1'(s)) begin
                rd_busy_q[s] <= 1'b1;
                rd_cnt_q[s] <= '0;
                rd_addr_q[s] <= s_addr;
            end else if (tick && rd_busy_q[s]) begin
                if (rd_cnt_q[s] == `QBSP_RD_BEAT3) begin
                    rd_busy_q[s] <= 1'b0;
                end
                rd_cnt_q[s] <= rd_cnt_q[s] + 3'h1;
            end
        end

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                wr_busy_q[s] <= 1'b0;
                wr_cnt_q[s] <= '0;
                wr_addr_q[s] <= '0;
            end else if (wr_start && wr_slot_q == 1'(s)) begin
                wr_busy_q[s] <= 1'b1;
                wr_cnt_q[s] <= '0;
                wr_addr_q[s] <= s_addr;
            end else if (tick && wr_busy_q[s]) begin
                if (wr_cnt_q[s] == `QBSP_WR_BEAT3) begin
                    wr_busy_q[s] <= 1'b0;
                end
                wr_cnt_q[s] <= wr_cnt_q[s] + 3'h1;
            end
        end

        assign rd_drive[s] = rd_busy_q[s] && rd_cnt_q[s] >= `QBSP_RD_BEAT0;
        assign rd_vld[s] = rd_busy_q[s] && rd_cnt_q[s] >= `QBSP_RD_VLD_ON
            && rd_cnt_q[s] <= `QBSP_RD_VLD_LAST;
        assign wr_beat[s] = tick && wr_busy_q[s] && wr_cnt_q[s] >= `QBSP_WR_BEAT0
            && wr_cnt_q[s] <= `QBSP_WR_BEAT3;
    end

    // Storage, beat address is the loaded address with a two-bit offset appended below it
    logic [DATA_W-1:0] store_mem [2**MEM_A];
    logic wr_sel;
    logic rd_sel;
    logic [1:0] wr_off;
    logic [1:0] rd_off;
    logic [MEM_A-1:0] wr_maddr;
    logic [MEM_A-1:0] rd_maddr;

    assign wr_sel = wr_beat[1];
    assign rd_sel = rd_drive[1];
    assign wr_off = 2'(wr_cnt_q[wr_sel] - `QBSP_WR_BEAT0);
    assign rd_off = 2'(rd_cnt_q[rd_sel] - `QBSP_RD_BEAT0);
    assign wr_maddr = {wr_addr_q[wr_sel], wr_off};
    assign rd_maddr = {rd_addr_q[rd_sel], rd_off};

    // Strobes taken per beat, so each lane can differ beat by beat
    always_ff @(posedge clk) begin
        if (|wr_beat) begin
            for (int l = 0; l < LANES; l++) begin
                if (!s_bw_n[l]) begin
                    store_mem[wr_maddr][l*`QBSP_LANE_W +: `QBSP_LANE_W] <=
                        s_wdata[l*`QBSP_LANE_W +: `QBSP_LANE_W];
                end
            end
        end
    end

    // Read outputs; echo clocks taken one flop after the edge detector so they
    // leave on the same core edge as the beat they frame
    logic [DATA_W-1:0] read_data_q;
    logic read_data_oe_q;
    logic read_data_valid_q;
    logic echo_clock_q;
    logic echo_clock_complement_q;
    logic [DATA_W-1:0] read_data_d;

    assign read_data_d = (|rd_drive) ? store_mem[rd_maddr] : '0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            read_data_q <= '0;
            read_data_oe_q <= 1'b0;
            read_data_valid_q <= 1'b0;
            echo_clock_q <= 1'b0;
            echo_clock_complement_q <= 1'b0;
        end else begin
            read_data_q <= read_data_d;
            read_data_oe_q <= |rd_drive;
            read_data_valid_q <= |rd_vld;
            echo_clock_q <= kprev_q[1];
            echo_clock_complement_q <= kprev_q[0];
        end
    end

    // Clock setup monitor; a stall or a bypass change restarts it
    qbsp_setup_e setup_q;
    logic [11:0] setup_cnt_q;
    logic [11:0] stall_cnt_q;
    logic pll_prev_q;
    logic term_q;
    logic pll_q;
    logic setup_done_q;
    logic restart;

    assign restart = (s_pll != pll_prev_q) || (stall_cnt_q >= `QBSP_STALL_CYC);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stall_cnt_q <= '0;
            pll_prev_q <= 1'b0;
            term_q <= 1'b0;
            pll_q <= 1'b0;
        end else begin
            stall_cnt_q <= tick ? 12'h000 : stall_cnt_q + {11'h000, ~restart};
            pll_prev_q <= s_pll;
            term_q <= s_term;
            pll_q <= s_pll;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            setup_q <= QBSP_SETUP_IDLE;
            setup_cnt_q <= '0;
        end else begin
            case (setup_q)
                QBSP_SETUP_IDLE: begin
                    setup_cnt_q <= '0;
                    if (tick) begin
                        setup_q <= QBSP_SETUP_RUN;
                    end
                end
                QBSP_SETUP_RUN: begin
                    setup_cnt_q <= setup_cnt_q + 12'h001;
                    if (restart) begin
                        setup_q <= QBSP_SETUP_IDLE;
                    end else if (setup_cnt_q >= 12'(`QBSP_SETUP_CYC - 1)) begin
                        setup_q <= QBSP_SETUP_DONE;
                    end
                end
                QBSP_SETUP_DONE: begin
                    if (restart) begin
                        setup_q <= QBSP_SETUP_IDLE;
                    end
                end
                default: begin
                    setup_q <= QBSP_SETUP_IDLE;
                end
            endcase
        end
    end

    // Status leaves from a flop, one cycle behind the state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            setup_done_q <= 1'b0;
        end else begin
            setup_done_q <= (setup_q == QBSP_SETUP_DONE);
        end
    end

    assign read_data = read_data_q;
    assign read_data_oe = read_data_oe_q;
    assign read_data_valid = read_data_valid_q;
    assign echo_clock = echo_clock_q;
    assign echo_clock_complement = echo_clock_complement_q;
    assign term_range_high = term_q;
    assign pll_in_use = pll_q;
    assign clock_setup_done = setup_done_q;
endmodule : qbsp_port

// ### dv/qbsp_port_checker.sv
// Checker of the burst SRAM port: read timing, echo clocks, straps, setup.
// Assumes four core cycles per link half period and a link clock that never stops.
module qbsp_port_checker #(
    parameter int DATA_W = 36
) (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Straps
    input logic pll_bypass_n,
    input logic termination_range_select,
    // Read path and status
    input logic [DATA_W-1:0] read_data,
    input logic read_data_oe,
    input logic read_data_valid,
    input logic echo_clock,
    input logic echo_clock_complement,
    input logic term_range_high,
    input logic pll_in_use,
    input logic clock_setup_done
);
    // Saturating, so a long run never wraps into a false early count
    logic [11:0] cyc_q;
    logic [11:0] cyc_d;
    assign cyc_d = (cyc_q == 12'hFFF) ? cyc_q : cyc_q + 12'h001;
    always_ff @(posedge clk) begin
        cyc_q <= sys_rst ? 12'h000 : cyc_d;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_valid_lead: assert property (
        $rose(read_data_valid) |-> !read_data_oe ##4 $rose(read_data_oe))
        else $error("valid did not lead the first beat");
    a_valid_trail: assert property (
        $fell(read_data_valid) |-> read_data_oe ##4 $fell(read_data_oe))
        else $error("valid did not fall before the last beat");
    a_burst_len: assert property (
        $rose(read_data_oe) |-> read_data_oe[*8] ##1 read_data_oe[*8])
        else $error("read burst shorter than four beats");
    a_float_zero: assert property (
        !read_data_oe |-> read_data == '0)
        else $error("read data not quiet while released");
    a_valid_edge: assert property (
        $changed(read_data_valid) |-> $changed(echo_clock))
        else $error("valid moved off an echo edge");
    a_data_edge: assert property (
        $changed(read_data) |-> $changed(echo_clock))
        else $error("read data moved off an echo edge");
    a_echo_runs: assert property (
        $fell(echo_clock) |-> ##4 $rose(echo_clock))
        else $error("echo clock stopped");
    a_echo_pair: assert property (
        $changed(echo_clock) |-> echo_clock_complement == !echo_clock)
        else $error("echo clocks not complementary");
    a_term_range: assert property (
        $changed(termination_range_select) |-> ##[1:4] term_range_high == termination_range_select)
        else $error("termination range not taken");
    a_pll_mode: assert property (
        $changed(pll_bypass_n) |-> ##[1:4] pll_in_use == pll_bypass_n)
        else $error("pll mode not taken");
    a_setup_time: assert property (
        $rose(clock_setup_done) |-> cyc_q >= 12'h9C4)
        else $error("setup reported done too early");
    a_reset_quiet: assert property (
        $past(sys_rst) |-> !read_data_oe && !read_data_valid)
        else $error("read outputs active after reset");
endmodule : qbsp_port_checker

// ### dv/qbsp_ctrl_model.sv
// Controller model: makes the link clock pair and drives one link cycle per call.
// Assumes its caller spaces requests; values change 4 ns before the edge they serve.
module qbsp_ctrl_model (
    // Link clock pair
    output logic link_clk,
    output logic link_clk_n,
    // Commands and write path
    output logic read_sel_n,
    output logic write_sel_n,
    output logic [19:0] addr,
    output logic [35:0] write_data,
    output logic [3:0] byte_write_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        link_clk = 1'b0;
        read_sel_n = 1'b1;
        write_sel_n = 1'b1;
        addr = '0;
        write_data = '0;
        byte_write_strobe_n = 4'hF;
        #3;
        forever #32 link_clk = ~link_clk;
    end
    assign link_clk_n = ~link_clk;
    task automatic one_cycle(input logic rs, input logic ws, input logic [19:0] a,
        input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] s0, input logic [3:0] s1);
        @(posedge link_clk_n);
        #28;
        read_sel_n = rs;
        write_sel_n = ws;
        addr = a;
        write_data = d0;
        byte_write_strobe_n = s0;
        @(posedge link_clk);
        #28;
        read_sel_n = 1'b1;
        write_sel_n = 1'b1;
        // Address is don't care here, so it is scrambled rather than held
        addr = ~a;
        write_data = d1;
        byte_write_strobe_n = s1;
    endtask : one_cycle
endmodule : qbsp_ctrl_model

// ### dv/qbsp_port_tb.sv
// Bench of the burst SRAM port: a row table of link cycles, read beats checked in order.
// Assumes the controller model and the checker are compiled ahead of it.
module qbsp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, pll_bypass_n, termination_range_select;
    logic link_clk, link_clk_n, read_sel_n, write_sel_n;
    logic read_data_oe, read_data_valid, echo_clock, echo_clock_complement;
    logic term_range_high, pll_in_use, clock_setup_done;
    logic [19:0] addr;
    logic [35:0] write_data, read_data;
    logic [3:0] byte_write_strobe_n;
    logic [35:0] mem [int];
    logic [35:0] exp_q [$];
    int n_mismatch = 0;
    int total_checks = 0;
    // Row: read_sel_n, write_sel_n, word address, strobes for K then /K
    logic [15:0] rows [17] = '{16'h8500, 16'h8600, 16'h8500, 16'hC0E7, 16'h45F0, 16'h4600,
        16'h0500, 16'hC000, 16'h4500, 16'h8600, 16'hC000, 16'hC000, 16'h4600, 16'hC000,
        16'hC000, 16'hC000, 16'hC000};
    always #4 clk = ~clk;
    qbsp_ctrl_model u_ctl (.link_clk, .link_clk_n, .read_sel_n, .write_sel_n, .addr,
        .write_data, .byte_write_strobe_n);
    qbsp_port u_dut (.clk, .sys_rst, .link_clk, .link_clk_n, .read_sel_n, .write_sel_n, .addr,
        .write_data, .byte_write_strobe_n, .pll_bypass_n, .termination_range_select, .read_data,
        .read_data_oe, .read_data_valid, .echo_clock, .echo_clock_complement, .term_range_high,
        .pll_in_use, .clock_setup_done);
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic put(input int k, input logic [35:0] d, input logic [3:0] s);
        for (int l = 0; l < 4; l++) begin
            if (!s[l]) begin
                mem[k][9 * l +: 9] = d[9 * l +: 9];
            end
        end
    endtask : put
    function automatic logic [35:0] dat(input int j, input logic h);
        return 36'h9_1A2B_3C4D ^ {4{5'(2 * j + int'(h)), 4'h0}};
    endfunction : dat
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // A beat shows about 25 ns after its edge, so it is sampled 20 ns after the next one
    always @(posedge link_clk or posedge link_clk_n) begin
        #20;
        if (read_data_oe === 1'b1) begin
            check(read_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
    end
    initial begin
        logic [15:0] r;
        logic [35:0] d0, d1;
        logic rd, wr, prev_rd, prev_wr;
        int wr_at, wa;
        clk = 1'b0;
        sys_rst = 1'b1;
        // The slow bench link clock is only legal with the PLL off
        pll_bypass_n = 1'b0;
        termination_range_select = 1'b1;
        prev_rd = 1'b0;
        prev_wr = 1'b0;
        wr_at = -9;
        wa = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 3000 && clock_setup_done !== 1'b1; i++) @(posedge clk);
        check(clock_setup_done, 1'b1);
        if (clock_setup_done !== 1'b1) begin
            summarize();
        end
        check(term_range_high, 1'b1);
        check(pll_in_use, 1'b0);
        for (int j = 0; j < 17; j++) begin
            r = rows[j];
            d0 = dat(j, 1'b0);
            d1 = dat(j, 1'b1);
            if (j == wr_at + 1 || j == wr_at + 2) begin
                put(wa * 4 + 2 * (j - wr_at - 1), d0, r[7:4]);
                put(wa * 4 + 2 * (j - wr_at) - 1, d1, r[3:0]);
            end
            rd = !r[15] && !prev_rd;
            wr = r[15] && !r[14] && !prev_wr;
            for (int k = 0; k < 4 && rd; k++) begin
                exp_q.push_back(mem[int'(r[13:8]) * 4 + k]);
            end
            if (wr) begin
                wr_at = j;
                wa = int'(r[13:8]);
            end
            prev_rd = rd;
            prev_wr = wr;
            u_ctl.one_cycle(r[15], r[14], 20'(r[13:8]), d0, d1, r[7:4], r[3:0]);
        end
        check(exp_q.size(), 0);
        @(posedge clk);
        termination_range_select <= 1'b0;
        pll_bypass_n <= 1'b1;
        repeat (8) @(posedge clk);
        check(term_range_high, 1'b0);
        check(pll_in_use, 1'b1);
        check(clock_setup_done, 1'b0);
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        check({read_data_oe, read_data_valid, echo_clock}, 3'h0);
        summarize();
    end
endmodule : qbsp_port_tb
bind qbsp_port qbsp_port_checker #(.DATA_W(DATA_W)) u_chk (.clk, .sys_rst, .pll_bypass_n,
    .termination_range_select, .read_data, .read_data_oe, .read_data_valid, .echo_clock,
    .echo_clock_complement, .term_range_high, .pll_in_use, .clock_setup_done);
